// [rtl/mrp_poller.v]
// Serial request poller: request table, framing, CRC, response wait, buffer copy
//
// Functional notes
// RQ1: Block is master; slaves only answer requests.
// RQ2: Supports function codes 1-6, 15, 16.
// RQ3: Coil functions count bits, register functions words.
// RQ4: Single writes always move one point.
// RQ5: Coil/input reads and register reads behave alike.
// RQ6: Response timeout 1-255 units of 10ms, error 9.
// RQ7: Retry failed request; error after retries exhausted.
// RQ8: Pause of 10ms units before next request.
// RQ9: Pause setting zero acts as one unit.
// RQ10: Table of 24 entries with five fields.
// RQ11: Jump entry restarts at first entry.
// RQ12: Disabled entry is skipped.
// RQ13: Position zero places data after previous entries.
// RQ14: Read position zero after header; write at trigger.
// RQ15: Buffer is trigger, length, then process data.
// RQ16: Request frame: id, code, start, count, CRC.
// RQ17: CRC computed by block and appended.
// RQ18: Valid read data copied, registers high byte first.
// RQ19: Bits packed into bytes; length byte grows.
// RQ20: Data beyond point count leaves buffer unchanged.
// RQ21: Single coil on when mapped byte nonzero.
// RQ22: Slave echoes single register write request.
// RQ23: Entries polled ascending, wrapping continuously.
`timescale 1ns/1ps
`include "mrp_defines.vh"

module mrp_poller #(
  parameter ENTRIES = 24,
  parameter BUF_DEPTH = 256,
  parameter UNIT_CYCLES = `MRP_UNIT_NS / `MRP_CLK_NS
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [11:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg [7:0] tx_data_o,
  output reg tx_valid_o,
  input wire tx_ready_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i
);

  localparam [2:0] S_PICK = 3'h0;
  localparam [2:0] S_SEND = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_COPY = 3'h3;
  localparam [2:0] S_PAUSE = 3'h4;
  localparam [31:0] UNIT_LAST_W = UNIT_CYCLES - 1;
  localparam [31:0] LAST_ENTRY_W = ENTRIES - 1;
  localparam [23:0] UNIT_LAST = UNIT_LAST_W[23:0];
  localparam [4:0] LAST_ENTRY = LAST_ENTRY_W[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        r = r[0] ? ((r >> 1) ^ `MRP_CRC_POLY) : (r >> 1);
      end
      crc_step = r;
    end
  endfunction

  function is_bit_fc;
    input [7:0] fc;
    begin
      is_bit_fc = (fc == `MRP_FC_RD_COILS) || (fc == `MRP_FC_RD_INPUTS) ||
                  (fc == `MRP_FC_WR_COIL) || (fc == `MRP_FC_WR_COILS);
    end
  endfunction

  function is_read_fc;
    input [7:0] fc;
    begin
      is_read_fc = (fc >= `MRP_FC_RD_COILS) && (fc <= `MRP_FC_RD_INREG);
    end
  endfunction

  function is_multi_fc;
    input [7:0] fc;
    begin
      is_multi_fc = (fc == `MRP_FC_WR_COILS) || (fc == `MRP_FC_WR_REGS);
    end
  endfunction

  // Keeps only the bits of the last packed byte that the point count covers
  function [7:0] last_mask;
    input [15:0] n;
    begin
      last_mask = (n[2:0] == 3'h0) ? 8'hff : ((8'h01 << n[2:0]) - 8'h01);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage and configuration

  reg [31:0] ent_a [0:ENTRIES-1];
  reg [31:0] ent_b [0:ENTRIES-1];
  reg [7:0] in_buf [0:BUF_DEPTH-1];
  reg [7:0] out_buf [0:BUF_DEPTH-1];
  reg [7:0] rx_buf [0:255];
  reg ctrl_en;
  reg ctrl_trig;
  reg ctrl_len;
  reg [7:0] tmo_cfg;
  reg [7:0] retry_cfg;
  reg [7:0] delay_cfg;

  reg [2:0] state;
  reg [4:0] idx;
  reg [7:0] cur_id;
  reg [7:0] cur_fc;
  reg [15:0] cur_start;
  reg [15:0] cur_n;
  reg [7:0] cur_nb;
  reg [7:0] cur_dst;
  reg [8:0] tx_idx;
  reg [8:0] frame_len;
  reg [15:0] crc;
  reg [8:0] rx_cnt;
  reg [8:0] exp_len;
  reg [23:0] tick;
  reg [7:0] units;
  reg [7:0] retry_left;
  reg [7:0] auto_rd;
  reg [7:0] auto_wr;
  reg [8:0] cp;
  reg [7:0] err_code;
  reg [7:0] err_cnt;
  reg [7:0] tx_byte;
  integer k;

  wire [3:0] region = reg_addr_i[11:8];
  wire [7:0] word_idx = reg_addr_i[9:2];
  // Entry words sit in the low 24 words of their region
  wire [5:0] ent_idx = reg_addr_i[7:2];
  wire ent_hit = (ent_idx < ENTRIES);
  wire [1:0] base2 = {1'b0, ctrl_trig} + {1'b0, ctrl_len};
  wire [7:0] base_rd = {6'h00, base2};
  wire [7:0] len_pos = {7'h00, ctrl_trig};
  wire status_clr = reg_wr_i && (region == `MRP_REGION_MISC) &&
                    (reg_addr_i == `MRP_REG_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      {ctrl_len, ctrl_trig, ctrl_en} <= `MRP_CTRL_RST;
      tmo_cfg <= `MRP_TMO_RST;
      retry_cfg <= `MRP_RETRY_RST;
      delay_cfg <= `MRP_DELAY_RST;
      for (k = 0; k < ENTRIES; k = k + 1) begin
        ent_a[k] <= 32'h00000000;
        ent_b[k] <= 32'h00000000;
      end
      for (k = 0; k < BUF_DEPTH; k = k + 1) begin
        in_buf[k] <= 8'h00;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == `MRP_REG_CTRL) begin
        ctrl_en <= reg_wdata_i[`MRP_CTRL_EN_BIT];
        ctrl_trig <= reg_wdata_i[`MRP_CTRL_TRIG_BIT];
        ctrl_len <= reg_wdata_i[`MRP_CTRL_LEN_BIT];
      end
      if (reg_addr_i == `MRP_REG_TIMING) begin
        tmo_cfg <= reg_wdata_i[7:0];
        retry_cfg <= reg_wdata_i[15:8];
        delay_cfg <= reg_wdata_i[23:16];
      end
      if (region == `MRP_REGION_ENT_A && ent_hit) begin
        ent_a[ent_idx[4:0]] <= reg_wdata_i; // [RQ10]
      end
      if (region == `MRP_REGION_ENT_B && ent_hit) begin
        ent_b[ent_idx[4:0]] <= reg_wdata_i; // [RQ10]
      end
      if (reg_addr_i[11:10] == `MRP_REGION_IN_BUF) begin
        in_buf[word_idx] <= reg_wdata_i[7:0];
      end
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i || !reg_rd_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_addr_i == `MRP_REG_CTRL) begin
      reg_rdata_o <= {29'h00000000, ctrl_len, ctrl_trig, ctrl_en};
    end else if (reg_addr_i == `MRP_REG_TIMING) begin
      reg_rdata_o <= {8'h00, delay_cfg, retry_cfg, tmo_cfg};
    end else if (reg_addr_i == `MRP_REG_STATUS) begin
      reg_rdata_o <= {err_cnt, err_code, 5'h00, state, 3'h0, idx};
    end else if (region == `MRP_REGION_ENT_A && ent_hit) begin
      reg_rdata_o <= ent_a[ent_idx[4:0]];
    end else if (region == `MRP_REGION_ENT_B && ent_hit) begin
      reg_rdata_o <= ent_b[ent_idx[4:0]];
    end else if (reg_addr_i[11:10] == `MRP_REGION_IN_BUF) begin
      reg_rdata_o <= {24'h000000, in_buf[word_idx]};
    end else if (reg_addr_i[11:10] == `MRP_REGION_OUT_BUF) begin
      reg_rdata_o <= {24'h000000, out_buf[word_idx]};
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry decode

  wire [31:0] ea = ent_a[idx];
  wire [31:0] eb = ent_b[idx];
  wire [7:0] e_id = ea[7:0];
  wire [7:0] e_fc = ea[15:8];
  wire [15:0] e_start = ea[31:16];
  wire [7:0] e_map = eb[23:16];
  wire e_single = (e_fc == `MRP_FC_WR_COIL) || (e_fc == `MRP_FC_WR_REG);
  wire [15:0] e_n = e_single ? 16'h0001 : eb[15:0]; // [RQ4]
  wire [16:0] nb_bits = ({1'b0, e_n} + 17'h00007) >> 3; // [RQ19]
  wire [16:0] nb_words = {e_n, 1'b0}; // [RQ3] [RQ18]
  wire [7:0] e_nb = is_bit_fc(e_fc) ? nb_bits[7:0] : nb_words[7:0]; // [RQ3]
  wire e_rd = is_read_fc(e_fc); // [RQ5]
  // Chains restart at entry 0 in the same cycle that it is picked
  wire [7:0] auto_rd_now = (idx == 5'h00) ? 8'h00 : auto_rd;
  wire [7:0] auto_wr_now = (idx == 5'h00) ? base_rd : auto_wr;
  wire [7:0] e_pos = (e_map != 8'h00) ? e_map : (e_rd ? auto_rd_now : auto_wr_now); // [RQ13]
  wire [7:0] e_dst = e_rd ? base_rd + e_pos : e_pos; // [RQ14] [RQ15]
  wire e_valid_fc = e_rd || e_single || is_multi_fc(e_fc); // [RQ2]
  wire [4:0] idx_next = (idx == LAST_ENTRY) ? 5'h00 : idx + 5'h01; // [RQ23]

  ////////////////////////////////////////////////////////////////////////////
  // Request byte selection

  wire [8:0] tx_k = tx_idx - `MRP_MULTI_HDR;
  wire [7:0] tx_addr = cur_dst + tx_k[7:0];
  wire [7:0] dst_p1 = cur_dst + 8'h01;

  always @* begin
    case (tx_idx)
      9'h000: tx_byte = cur_id; // [RQ16]
      9'h001: tx_byte = cur_fc;
      9'h002: tx_byte = cur_start[15:8];
      9'h003: tx_byte = cur_start[7:0];
      9'h004: begin
        if (cur_fc == `MRP_FC_WR_COIL) begin
          tx_byte = (in_buf[cur_dst] != 8'h00) ? `MRP_COIL_ON : 8'h00; // [RQ21]
        end else if (cur_fc == `MRP_FC_WR_REG) begin
          tx_byte = in_buf[cur_dst];
        end else begin
          tx_byte = cur_n[15:8];
        end
      end
      9'h005: begin
        if (cur_fc == `MRP_FC_WR_COIL) begin
          tx_byte = 8'h00;
        end else if (cur_fc == `MRP_FC_WR_REG) begin
          tx_byte = in_buf[dst_p1];
        end else begin
          tx_byte = cur_n[7:0];
        end
      end
      9'h006: tx_byte = cur_nb;
      default: begin
        if (cur_fc == `MRP_FC_WR_COILS && tx_k[7:0] == cur_nb - 8'h01) begin
          tx_byte = in_buf[tx_addr] & last_mask(cur_n); // [RQ20]
        end else begin
          tx_byte = in_buf[tx_addr];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response checks and timing

  wire [15:0] rx_crc_next = crc_step(crc, rx_data_i);
  wire rx_last = (state == S_WAIT) && rx_valid_i && (rx_cnt + 9'h001 == exp_len);
  wire rx_good = rx_last && (rx_crc_next == 16'h0000) && (rx_buf[0] == cur_id) &&
                 (rx_buf[1] == cur_fc) &&
                 (!is_read_fc(cur_fc) || rx_buf[2] == cur_nb); // [RQ22]
  wire unit_end = (tick == UNIT_LAST);
  wire [7:0] tmo_eff = (tmo_cfg == 8'h00) ? 8'h01 : tmo_cfg;
  wire [7:0] delay_eff = (delay_cfg == 8'h00) ? 8'h01 : delay_cfg; // [RQ9]
  wire timed_out = (state == S_WAIT) && !rx_last && unit_end &&
                   (units + 8'h01 == tmo_eff); // [RQ6]
  wire fail = (rx_last && !rx_good) || timed_out;
  wire [8:0] cp_next = cp + 9'h001;
  wire [7:0] cp_addr = cur_dst + cp[7:0];
  wire [7:0] rx_byte = rx_buf[cp[7:0] + 8'h03];
  wire [7:0] cp_mask = (is_bit_fc(cur_fc) && cp_next[7:0] == cur_nb) ?
                       last_mask(cur_n) : 8'hff;
  wire [7:0] len_new = cur_dst + cur_nb - base_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= S_PICK;
      idx <= 5'h00;
      cur_id <= 8'h00;
      cur_fc <= 8'h00;
      cur_start <= 16'h0000;
      cur_n <= 16'h0000;
      cur_nb <= 8'h00;
      cur_dst <= 8'h00;
      tx_idx <= 9'h000;
      frame_len <= `MRP_FRAME_SHORT;
      crc <= `MRP_CRC_INIT;
      rx_cnt <= 9'h000;
      exp_len <= `MRP_FRAME_SHORT;
      tick <= 24'h000000;
      units <= 8'h00;
      retry_left <= 8'h00;
      auto_rd <= 8'h00;
      auto_wr <= 8'h00;
      cp <= 9'h000;
      err_code <= `MRP_ERR_NONE;
      err_cnt <= 8'h00;
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      for (k = 0; k < BUF_DEPTH; k = k + 1) begin
        out_buf[k] <= 8'h00;
      end
    end else begin
      if (status_clr) begin
        err_code <= `MRP_ERR_NONE;
        err_cnt <= 8'h00;
      end
      if (tx_valid_o && tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
      case (state)
        S_PICK: begin
          if (idx == 5'h00) begin
            auto_rd <= 8'h00;
            auto_wr <= base_rd;
          end
          if (ctrl_en) begin
            if (e_fc == `MRP_FC_JUMP) begin
              idx <= 5'h00; // [RQ11]
            end else if (!e_valid_fc) begin
              idx <= idx_next; // [RQ12] [RQ23]
            end else begin
              cur_id <= e_id;
              cur_fc <= e_fc;
              cur_start <= e_start;
              cur_n <= e_n;
              cur_nb <= e_nb;
              cur_dst <= e_dst;
              if (e_rd) begin
                auto_rd <= e_pos + e_nb; // [RQ13]
              end else begin
                auto_wr <= e_pos + e_nb;
              end
              frame_len <= is_multi_fc(e_fc) ?
                           `MRP_MULTI_HDR + {1'b0, e_nb} + 9'h002 : `MRP_FRAME_SHORT;
              retry_left <= retry_cfg;
              tx_idx <= 9'h000;
              crc <= `MRP_CRC_INIT;
              state <= S_SEND; // [RQ1]
            end
          end
        end
        S_SEND: begin
          if (!tx_valid_o) begin
            tx_valid_o <= 1'b1;
            tx_idx <= tx_idx + 9'h001;
            if (tx_idx + 9'h002 == frame_len) begin
              tx_data_o <= crc[7:0]; // [RQ17]
            end else if (tx_idx + 9'h001 == frame_len) begin
              tx_data_o <= crc[15:8]; // [RQ17]
              exp_len <= is_read_fc(cur_fc) ? `MRP_RESP_HDR + {1'b0, cur_nb} :
                         `MRP_FRAME_SHORT;
              rx_cnt <= 9'h000;
              crc <= `MRP_CRC_INIT;
              tick <= 24'h000000;
              units <= 8'h00;
              state <= S_WAIT;
            end else begin
              tx_data_o <= tx_byte;
              crc <= crc_step(crc, tx_byte); // [RQ17]
            end
          end
        end
        S_WAIT: begin
          tick <= unit_end ? 24'h000000 : tick + 24'h000001;
          if (unit_end) begin
            units <= units + 8'h01;
          end
          if (rx_valid_i && rx_cnt < exp_len) begin
            rx_buf[rx_cnt[7:0]] <= rx_data_i;
            rx_cnt <= rx_cnt + 9'h001;
            crc <= rx_crc_next;
            if (rx_cnt == 9'h001 && rx_data_i[7]) begin
              exp_len <= `MRP_RESP_EXC;
            end
          end
          if (rx_good) begin
            cp <= 9'h000;
            tick <= 24'h000000;
            units <= 8'h00;
            state <= is_read_fc(cur_fc) ? S_COPY : S_PAUSE; // [RQ18]
          end else if (fail) begin
            tick <= 24'h000000;
            units <= 8'h00;
            if (retry_left != 8'h00) begin
              retry_left <= retry_left - 8'h01; // [RQ7]
              tx_idx <= 9'h000;
              crc <= `MRP_CRC_INIT;
              state <= S_SEND;
            end else begin
              err_code <= `MRP_ERR_TIMEOUT; // [RQ6] [RQ7]
              err_cnt <= err_cnt + 8'h01;
              state <= S_PAUSE;
            end
          end
        end
        S_COPY: begin
          if (cp[7:0] < cur_nb) begin
            out_buf[cp_addr] <= (rx_byte & cp_mask) |
                                (out_buf[cp_addr] & ~cp_mask); // [RQ18] [RQ20]
            cp <= cp_next;
          end else begin
            if (ctrl_len && len_new > out_buf[len_pos]) begin
              out_buf[len_pos] <= len_new; // [RQ19] [RQ15]
            end
            state <= S_PAUSE;
          end
        end
        S_PAUSE: begin
          tick <= unit_end ? 24'h000000 : tick + 24'h000001;
          if (unit_end) begin
            units <= units + 8'h01;
            if (units + 8'h01 == delay_eff) begin
              units <= 8'h00;
              idx <= idx_next; // [RQ8] [RQ23]
              state <= S_PICK;
            end
          end
        end
        default: state <= S_PICK;
      endcase
    end
  end

endmodule

// [rtl/mrp_defines.vh]
// Constants for the serial request poller: register map, fields, codes, timing
`ifndef MRP_DEFINES_VH
`define MRP_DEFINES_VH

`define MRP_ADDR_W 12
`define MRP_REG_CTRL 12'h000
`define MRP_REG_TIMING 12'h004
`define MRP_REG_STATUS 12'h008
`define MRP_REGION_MISC 4'h0
`define MRP_REGION_ENT_A 4'h1
`define MRP_REGION_ENT_B 4'h2
`define MRP_REGION_IN_BUF 2'h1
`define MRP_REGION_OUT_BUF 2'h2

`define MRP_CTRL_EN_BIT 0
`define MRP_CTRL_TRIG_BIT 1
`define MRP_CTRL_LEN_BIT 2
`define MRP_CTRL_RST 3'h0
`define MRP_TMO_RST 8'h19
`define MRP_RETRY_RST 8'h00
`define MRP_DELAY_RST 8'h00

`define MRP_FC_DISABLED 8'h00
`define MRP_FC_RD_COILS 8'h01
`define MRP_FC_RD_INPUTS 8'h02
`define MRP_FC_RD_HOLD 8'h03
`define MRP_FC_RD_INREG 8'h04
`define MRP_FC_WR_COIL 8'h05
`define MRP_FC_WR_REG 8'h06
`define MRP_FC_WR_COILS 8'h0f
`define MRP_FC_WR_REGS 8'h10
`define MRP_FC_JUMP 8'hff

`define MRP_ERR_NONE 8'h00
`define MRP_ERR_TIMEOUT 8'h09
`define MRP_COIL_ON 8'hff
`define MRP_CRC_INIT 16'hffff
`define MRP_CRC_POLY 16'ha001
`define MRP_FRAME_SHORT 9'h008
`define MRP_MULTI_HDR 9'h007
`define MRP_RESP_HDR 9'h005
`define MRP_RESP_EXC 9'h005

`define MRP_UNIT_NS 10000000
`define MRP_CLK_NS 50

`endif

// [bench/mrp_poller_chk.sv]
// Port-level assertions for the serial request poller
`timescale 1ns/1ps
module mrp_poller_chk #(
  parameter ENTRIES = 24,
  parameter BUF_DEPTH = 256,
  parameter UNIT_CYCLES = 200000
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [11:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire [7:0] tx_data_o,
  input wire tx_valid_o,
  input wire tx_ready_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i
);
  reg [19:0] gap;
  reg [19:0] since_rx;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Saturating ages of the last accepted request byte and last answer byte
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      gap <= 20'hfffff;
      since_rx <= 20'hfffff;
    end else begin
      gap <= (tx_valid_o && tx_ready_i) ? 20'h00001 : gap + {19'h0, gap != 20'hfffff};
      since_rx <= rx_valid_i ? 20'h00000 : since_rx + {19'h0, since_rx != 20'hfffff};
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_rd: assert property (reg_rd_i && reg_addr_i == 12'hffc |=> reg_rdata_o == 0)
    else $error("unmapped read returned data");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("request byte changed before acceptance");
  a_tx_bubble: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no idle cycle after an accepted byte");
  a_reset_idle: assert property ($fell(sys_rst_i) |-> !tx_valid_o && tx_data_o == 8'h00)
    else $error("outputs not idle after reset");
  a_rx_no_tx: assert property (rx_valid_i |-> !tx_valid_o)
    else $error("request sent while slave answers");
  a_frame_gap: assert property ($rose(tx_valid_o) |-> gap == 20'd2 || gap >= UNIT_CYCLES)
    else $error("new request before wait ended");
  a_pause_gap: assert property ($rose(tx_valid_o) |-> since_rx >= UNIT_CYCLES)
    else $error("pause after answer shorter than one unit");
  c_tx: cover property (tx_valid_o && tx_ready_i);
  c_rx: cover property (rx_valid_i);
  c_rd: cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
endmodule
bind mrp_poller mrp_poller_chk #(.ENTRIES(ENTRIES), .BUF_DEPTH(BUF_DEPTH),
  .UNIT_CYCLES(UNIT_CYCLES)) u_mrp_poller_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i),
  .rx_valid_i(rx_valid_i));

// [bench/mrp_slave_model.sv]
// Behavioural serial slave that answers request frames
`timescale 1ns/1ps
module mrp_slave_model (
  input wire clk_i,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output reg tx_ready_o = 1'b0,
  output reg [7:0] rx_data_o = 8'h00,
  output reg rx_valid_o = 1'b0
);
  logic [7:0] seen[$];
  logic [7:0] fr[$];
  logic [7:0] rsp[$];
  int n_frames = 0;
  int last_len = 0;
  int hold = 0;
  bit silent = 1'b0;
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic reply();
    logic [15:0] n;
    logic [15:0] c;
    n = {fr[4], fr[5]};
    rsp = {fr[0], fr[1]};
    if (fr[1] <= 8'h04) begin
      rsp.push_back(fr[1] <= 8'h02 ? 8'((n + 7) / 8) : 8'(2 * n));
      // Pattern bytes fill every bit, padding bits included, so padding must be ignored
      for (int k = 0; k < rsp[2]; k++) rsp.push_back((fr[3] + 8'(k)) ^ 8'h5a);
    end else begin
      rsp = {rsp, fr[2], fr[3], fr[4], fr[5]};
    end
    c = crc16(rsp);
    rsp = {rsp, c[7:0], c[15:8]};
  endtask
  always @(posedge clk_i) begin
    tx_ready_o <= ($urandom % 3) != 0;
    rx_valid_o <= 1'b0;
    if (rx_valid_o) rx_data_o <= ~rx_data_o;
    if (tx_valid_i && tx_ready_o) begin
      seen.push_back(tx_data_i);
      fr.push_back(tx_data_i);
      if (fr.size() == ((fr.size() > 6 && fr[1] > 8'h0e) ? 9 + fr[6] : 8)) begin
        n_frames++;
        last_len = fr.size();
        if (!silent) reply();
        hold = 4;
        fr.delete();
      end
    end else if (hold > 0) hold--;
    else if (rsp.size() != 0 && !rx_valid_o) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= rsp.pop_front();
    end
  end
endmodule

// [bench/test_mrp_poller.sv]
// Self-checking bench for the serial request poller
`timescale 1ns/1ps
`include "mrp_defines.vh"
module test_mrp_poller;
  localparam int UNIT = 8;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [11:0] reg_addr_i = 12'h000;
  reg [31:0] reg_wdata_i = 32'h0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire [7:0] tx_data_o;
  wire tx_valid_o;
  wire tx_ready_i;
  wire [7:0] rx_data_i;
  wire rx_valid_i;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [7:0] id [11];
  logic [7:0] fc [11] = '{8'h03, 8'h00, 8'h01, 8'h06, 8'h05, 8'h05, 8'h10, 8'h04, 8'h02, 8'h0f,
                          8'hff};
  logic [15:0] st [11];
  logic [15:0] cnt [11] = '{2, 0, 10, 0, 0, 0, 2, 1, 3, 16, 0};
  int pos [11] = '{0, 0, 0, 7, 9, 10, 11, 0, 0, 14, 0};
  logic [7:0] ib [16];
  logic [7:0] ob [12];
  logic [7:0] exp_q[$];
  logic [7:0] sq[$];
  logic [31:0] d;
  int p;
  int n0;
  always #25 clk_i = ~clk_i;
  mrp_poller #(.UNIT_CYCLES(UNIT)) u_mrp_poller (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i));
  mrp_slave_model u_mrp_slave_model (.clk_i(clk_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i),
    .rx_valid_o(rx_valid_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic exp_frame(input int i);
    logic [7:0] f[$];
    logic [15:0] c;
    f = {id[i], fc[i], st[i][15:8], st[i][7:0]};
    if (fc[i] == 8'h05) f = {f, (ib[pos[i]] != 8'h00) ? 8'hff : 8'h00, 8'h00};
    else if (fc[i] == 8'h06) f = {f, ib[pos[i]], ib[pos[i] + 1]};
    else f = {f, cnt[i][15:8], cnt[i][7:0]};
    if (fc[i] > 8'h0e) f.push_back(8'((fc[i] == 8'h10) ? 2 * cnt[i] : cnt[i] / 8));
    for (int k = 0; fc[i] > 8'h0e && k < f[6]; k++) f.push_back(ib[pos[i] + k]);
    c = u_mrp_slave_model.crc16(f);
    exp_q = {exp_q, f, c[7:0], c[15:8]};
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end
  initial begin
    void'($urandom(48));
    for (int i = 0; i < 11; i++) id[i] = (i == 3) ? 8'h01 : 8'(i + 1);
    for (int i = 0; i < 11; i++) st[i] = (i == 3) ? 16'h0005 : 16'($urandom);
    for (int b = 0; b < 16; b++) ib[b] = 8'($urandom);
    ib[7] = 8'hff;
    ib[8] = 8'h23;
    ib[9] = ib[9] | 8'h01;
    ib[10] = 8'h00;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`MRP_REG_CTRL, d); check("ctrl", d, 32'h0);
    rd(`MRP_REG_TIMING, d); check("timing", d, {24'h0, `MRP_TMO_RST});
    rd(`MRP_REG_STATUS, d); check("status", d, 32'h0);
    wr(12'hffc, 32'($urandom));
    rd(12'hffc, d); check("unmapped", d, 32'h0);
    wr(12'h160, 32'h0000_0301);
    rd(12'h160, d); check("entry 24", d, 32'h0);
    check("crc", u_mrp_slave_model.crc16({8'h01, 8'h06, 8'h00, 8'h05, ib[7], ib[8]}), 16'he299);
    for (int i = 0; i < 11; i++) wr(12'h100 + 12'(4 * i), {st[i], fc[i], id[i]});
    for (int i = 0; i < 11; i++) wr(12'h200 + 12'(4 * i), {8'h00, 8'(pos[i]), cnt[i]});
    for (int b = 0; b < 16; b++) wr(12'h400 + 12'(4 * b), {24'h0, ib[b]});
    rd(12'h108, d); check("entry", d, {st[2], fc[2], id[2]});
    wr(`MRP_REG_TIMING, 32'h0000_0019);
    wr(`MRP_REG_CTRL, 32'h0000_0007);
    foreach (fc[i]) if (fc[i] != 8'h00 && fc[i] != 8'hff) exp_frame(i);
    exp_frame(0);
    for (int t = 0; t < 20000 && u_mrp_slave_model.n_frames < 10; t++) @(posedge clk_i);
    repeat (100) @(posedge clk_i);
    sq = u_mrp_slave_model.seen;
    foreach (exp_q[k]) check("tx", sq[k], exp_q[k]);
    ob = '{default: 8'h00};
    p = 2;
    foreach (fc[i]) if (fc[i] >= 8'h01 && fc[i] <= 8'h04) begin
      for (int k = 0; k < ((fc[i] <= 8'h02) ? (cnt[i] + 7) / 8 : 2 * cnt[i]); k++) begin
        ob[p] = (st[i][7:0] + 8'(k)) ^ 8'h5a;
        p++;
      end
      if (fc[i] <= 8'h02 && cnt[i] % 8 != 0) ob[p - 1] &= 8'((1 << (cnt[i] % 8)) - 1);
    end
    ob[1] = 8'(p - 2);
    wr(12'h800, 32'h0000_00ff);
    for (int b = 0; b < 12; b++) begin
      rd(12'h800 + 12'(4 * b), d);
      check("obuf", d, {24'h0, ob[b]});
    end
    // Timeout with one retry against a silent slave
    wr(`MRP_REG_CTRL, 32'h0000_0006);
    repeat (3000) @(posedge clk_i);
    u_mrp_slave_model.silent = 1'b1;
    wr(`MRP_REG_TIMING, 32'h0000_0102);
    wr(`MRP_REG_STATUS, 32'h0);
    n0 = u_mrp_slave_model.n_frames;
    wr(`MRP_REG_CTRL, 32'h0000_0007);
    d = 32'h0;
    for (int t = 0; t < 500 && d[23:16] !== `MRP_ERR_TIMEOUT; t++) rd(`MRP_REG_STATUS, d);
    check("error", d[31:16], {8'h01, `MRP_ERR_TIMEOUT});
    check("tries", u_mrp_slave_model.n_frames - n0, 2);
    sq = u_mrp_slave_model.seen;
    p = sq.size() - u_mrp_slave_model.last_len;
    for (int k = 0; k < u_mrp_slave_model.last_len; k++)
      check("retry", sq[p + k], sq[p - u_mrp_slave_model.last_len + k]);
    complete_run();
  end
endmodule
